//--- drc_top.sv
// DRAM refresh control with APB register access, refresh sequencer and DMA acknowledge.
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module drc_top
    import drc_pkg::*;
(
    input wire logic pclk, // System clock, 40 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error for unmapped address.
    input wire logic hw_standby_n, // Hardware standby pin, low enters standby.
    input wire logic sw_standby, // Software standby request, same clock.
    input wire logic dram_req, // DRAM access request from bus, same clock.
    input wire logic dram_addr_hit, // Access address lies in DRAM space.
    input wire logic dma_master, // Current master is the DMA controller.
    input wire logic dma_single, // DMA transfer is in single address mode.
    input wire logic burst_mode, // Burst mode selected for the DRAM interface.
    output logic ras_n, // Row strobe, active low.
    output logic cas_n, // Column strobe, active low.
    output logic refresh_busy, // Refresh cycle in progress.
    output logic self_refresh, // Self-refresh drive to DRAM.
    output logic burst_access, // Burst access chosen for this access.
    output logic dma_ack_n, // DMA acknowledge, active low.
    output logic irq // Level interrupt.
);
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic dds_reg;
    logic [7:0] cmp_reg;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic [1:0] stat_reg;
    logic [1:0] stat_next;
    logic [1:0] ien_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic ras_n_reg;
    logic cas_n_reg;
    logic busy_reg;
    logic self_reg;
    logic burst_reg;
    logic ack_n_reg;
    logic irq_reg;
    logic rfsh_pend_reg;
    logic wait_reg;
    drc_rstate_e rstate_reg;
    drc_rstate_e rstate_next;
    drc_astate_e astate_reg;
    drc_astate_e astate_next;
    logic hw_stby;
    logic hw_pin;
    logic tick;
    logic match;
    logic apb_setup;
    logic wr_ctrl;
    logic wr_dma;
    logic wr_cmp;
    logic wr_cnt;
    logic wr_ien;
    logic wr_iclr;
    logic addr_ok;
    logic rfsh_en;
    logic rfsh_start;
    logic ras_fall;
    logic cas_low;
    logic burst_sel;
    logic ack_low;
    logic [31:0] rd_mux;
    logic [1:0] ev;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    drc_sync u_hw_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(hw_standby_n),
        .level(hw_pin)
    );
    assign hw_stby = !hw_pin;

    drc_prescale u_prescale (
        .pclk(pclk),
        .presetn(presetn),
        .clk_sel(ctrl_reg[2:0]),
        .tick(tick)
    );

    // Ready is registered from the setup cycle so every access takes two cycles; writes land in the enable cycle.
    assign apb_setup = psel && !penable;
    assign addr_ok = hit(paddr, DRC_OFF_CTRL) || hit(paddr, DRC_OFF_DMA) ||
        hit(paddr, DRC_OFF_CMP) || hit(paddr, DRC_OFF_CNT) || hit(paddr, DRC_OFF_STAT) ||
        hit(paddr, DRC_OFF_IEN) || hit(paddr, DRC_OFF_ICLR);
    assign wr_ctrl = psel && penable && pwrite && hit(paddr, DRC_OFF_CTRL);
    assign wr_dma = psel && penable && pwrite && hit(paddr, DRC_OFF_DMA);
    assign wr_cmp = psel && penable && pwrite && hit(paddr, DRC_OFF_CMP);
    assign wr_cnt = psel && penable && pwrite && hit(paddr, DRC_OFF_CNT);
    assign wr_ien = psel && penable && pwrite && hit(paddr, DRC_OFF_IEN);
    assign wr_iclr = psel && penable && pwrite && hit(paddr, DRC_OFF_ICLR);

    assign rd_mux = hit(paddr, DRC_OFF_CTRL) ? {24'h000000, ctrl_reg} :
        hit(paddr, DRC_OFF_DMA) ? {31'h00000000, dds_reg} :
        hit(paddr, DRC_OFF_CMP) ? {24'h000000, cmp_reg} :
        hit(paddr, DRC_OFF_CNT) ? {24'h000000, cnt_reg} :
        hit(paddr, DRC_OFF_STAT) ? {30'h00000000, stat_reg} :
        hit(paddr, DRC_OFF_IEN) ? {30'h00000000, ien_reg} : 32'h00000000;

    // Counter runs in both modes; as interval timer when refresh is off.
    assign match = tick && (cnt_reg == cmp_reg);
    assign cnt_next = wr_cnt ? pwdata[7:0] : match ? 8'h00 : tick ? cnt_reg + 8'h01 : cnt_reg;
    assign rfsh_en = ctrl_reg[DRC_BIT_RFSH_EN];

    // Hardware sets the match flag ahead of a software write of the same bit.
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next = pwdata[7:0];
        end
        if (match) begin
            ctrl_next[DRC_BIT_CMF] = 1'b1;
        end
    end

    assign ev = {busy_reg && (rstate_reg == DRC_RFSH_CAS2), match};
    assign stat_next = (stat_reg & ~(wr_iclr ? pwdata[1:0] : 2'h0)) | ev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= DRC_CTRL_RESET;
        end else if (hw_stby) begin
            ctrl_reg <= DRC_CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dds_reg <= 1'b0;
            cmp_reg <= DRC_CMP_RESET;
            cnt_reg <= 8'h00;
            stat_reg <= DRC_EV_RESET;
            ien_reg <= DRC_EV_RESET;
        end else begin
            dds_reg <= wr_dma ? pwdata[DRC_BIT_DDS] : dds_reg;
            cmp_reg <= wr_cmp ? pwdata[7:0] : cmp_reg;
            cnt_reg <= cnt_next;
            stat_reg <= stat_next;
            ien_reg <= wr_ien ? pwdata[1:0] : ien_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg <= (apb_setup && !pwrite) ? rd_mux : prdata_reg;
            pready_reg <= apb_setup;
            pslverr_reg <= apb_setup && !addr_ok;
        end
    end

    // Refresh request stays pending until the sequencer takes it or refresh is disabled.
    assign rfsh_start = rfsh_pend_reg && rfsh_en && (rstate_reg == DRC_IDLE) &&
        (astate_reg == DRC_ACC_IDLE) && !sw_standby;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rfsh_pend_reg <= 1'b0;
            wait_reg <= 1'b0;
        end else begin
            rfsh_pend_reg <= rfsh_en && (match || (rfsh_pend_reg && !rfsh_start));
            // The wait choice is held for the whole sequence so a write cannot tear it.
            wait_reg <= rfsh_start ? ctrl_reg[DRC_BIT_WAIT] : wait_reg;
        end
    end

    always_comb begin
        rstate_next = rstate_reg;
        unique case (rstate_reg)
            DRC_IDLE: begin
                if (rfsh_start) begin
                    rstate_next = DRC_RFSH_FIRST;
                end
            end
            DRC_RFSH_FIRST: begin
                rstate_next = wait_reg ? DRC_RFSH_WAIT : DRC_RFSH_CAS1;
            end
            DRC_RFSH_WAIT: begin
                rstate_next = DRC_RFSH_CAS1;
            end
            DRC_RFSH_CAS1: begin
                rstate_next = DRC_RFSH_CAS2;
            end
            DRC_RFSH_CAS2: begin
                rstate_next = DRC_IDLE;
            end
            default: begin
                rstate_next = DRC_IDLE;
            end
        endcase
    end

    // CAS falls with RAS or ahead of it; RAS falls either in the first state or the first CAS state.
    assign cas_low = (rstate_reg != DRC_IDLE);
    assign ras_fall = wait_reg ?
        (rstate_reg == DRC_RFSH_CAS1 || rstate_reg == DRC_RFSH_CAS2) :
        (rstate_reg != DRC_IDLE);

    always_comb begin
        astate_next = astate_reg;
        unique case (astate_reg)
            DRC_ACC_IDLE: begin
                if (dram_req && dram_addr_hit && rstate_reg == DRC_IDLE && !rfsh_pend_reg) begin
                    astate_next = DRC_ACC_ROW;
                end
            end
            DRC_ACC_ROW: begin
                astate_next = DRC_ACC_COL1;
            end
            DRC_ACC_COL1: begin
                astate_next = DRC_ACC_COL2;
            end
            DRC_ACC_COL2: begin
                astate_next = (burst_sel && dram_req && dram_addr_hit) ? DRC_ACC_COL1 : DRC_ACC_IDLE;
            end
        endcase
    end

    // Timing select one ignores master; zero withholds burst from single-address DMA.
    assign burst_sel = burst_mode && dram_addr_hit &&
        (dds_reg || !(dma_master && dma_single));
    assign ack_low = dma_master && dma_single && (dds_reg ?
        (astate_reg == DRC_ACC_COL1 || astate_reg == DRC_ACC_COL2) :
        (astate_reg != DRC_ACC_IDLE));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rstate_reg <= DRC_IDLE;
            astate_reg <= DRC_ACC_IDLE;
        end else begin
            rstate_reg <= rstate_next;
            astate_reg <= astate_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ras_n_reg <= 1'b1;
            cas_n_reg <= 1'b1;
            busy_reg <= 1'b0;
            self_reg <= 1'b0;
            burst_reg <= 1'b0;
            ack_n_reg <= 1'b1;
            irq_reg <= 1'b0;
        end else begin
            ras_n_reg <= !(ras_fall || self_reg || astate_reg != DRC_ACC_IDLE);
            cas_n_reg <= !(cas_low || self_reg || astate_reg == DRC_ACC_COL1 ||
                astate_reg == DRC_ACC_COL2);
            busy_reg <= (rstate_next != DRC_IDLE);
            self_reg <= sw_standby && rfsh_en && ctrl_reg[DRC_BIT_SELF];
            burst_reg <= burst_sel && (astate_reg != DRC_ACC_IDLE);
            ack_n_reg <= !ack_low;
            irq_reg <= ((stat_next & ien_reg) != 2'h0) ||
                (ctrl_next[DRC_BIT_CMF] && ctrl_next[DRC_BIT_COMPARE_MATCH_IRQ_ENABLE]);
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign ras_n = ras_n_reg;
    assign cas_n = cas_n_reg;
    assign refresh_busy = busy_reg;
    assign self_refresh = self_reg;
    assign burst_access = burst_reg;
    assign dma_ack_n = ack_n_reg;
    assign irq = irq_reg;

    a_reg_reset_hw: assert property (@(posedge pclk) disable iff (!presetn)
        hw_stby |=> (ctrl_reg == DRC_CTRL_RESET)) else $error("control not cleared in standby");
    a_reg_keep_sw: assert property (@(posedge pclk) disable iff (!presetn)
        (sw_standby && !hw_stby && !wr_ctrl && !match) |=> $stable(ctrl_reg))
        else $error("control changed in software standby");
    a_reg_write_back: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ctrl && !hw_stby && !match) |=> (ctrl_reg == $past(pwdata[7:0])))
        else $error("control write lost");
    a_no_refresh_off: assert property (@(posedge pclk) disable iff (!presetn)
        (!rfsh_en && rstate_reg == DRC_IDLE) |=> (rstate_reg == DRC_IDLE))
        else $error("refresh started while disabled");
    a_timer_runs_off: assert property (@(posedge pclk) disable iff (!presetn)
        (match && !hw_stby) |=> ctrl_reg[DRC_BIT_CMF]) else $error("match flag not set");
    sequence s_nowait_start;
        rstate_reg == DRC_IDLE && rfsh_start && !ctrl_reg[DRC_BIT_WAIT];
    endsequence
    sequence s_wait_start;
        rstate_reg == DRC_IDLE && rfsh_start && ctrl_reg[DRC_BIT_WAIT];
    endsequence
    a_ras_nowait: assert property (@(posedge pclk) disable iff (!presetn)
        s_nowait_start |=> ##1 !ras_n && busy_reg) else $error("ras late without wait");
    a_ras_wait: assert property (@(posedge pclk) disable iff (!presetn)
        s_wait_start |=> ##1 ras_n ##1 ras_n ##1 !ras_n) else $error("wait state timing wrong");
    a_self_refresh: assert property (@(posedge pclk) disable iff (!presetn)
        self_refresh == $past(sw_standby && rfsh_en && ctrl_reg[DRC_BIT_SELF]))
        else $error("self refresh mismatch");
    a_burst_addr: assert property (@(posedge pclk) disable iff (!presetn)
        (dds_reg && burst_mode && dram_addr_hit && astate_reg != DRC_ACC_IDLE) |=> burst_access)
        else $error("burst not by address");
    a_ack_column: assert property (@(posedge pclk) disable iff (!presetn)
        (dds_reg && dma_master && dma_single && astate_reg == DRC_ACC_ROW) |=> ##1 !dma_ack_n)
        else $error("ack not low in column state");
    sequence s_busy_three;
        refresh_busy[*3] ##1 !refresh_busy;
    endsequence
    sequence s_busy_four;
        refresh_busy[*4] ##1 !refresh_busy;
    endsequence
    a_busy_nowait: assert property (@(posedge pclk) disable iff (!presetn)
        s_nowait_start |=> s_busy_three) else $error("refresh length without wait wrong");
    a_busy_wait: assert property (@(posedge pclk) disable iff (!presetn)
        s_wait_start |=> s_busy_four) else $error("refresh length with wait wrong");
    a_cas_before_ras: assert property (@(posedge pclk) disable iff (!presetn)
        (refresh_busy && !ras_n) |-> !cas_n) else $error("row strobe low without column strobe");
    a_self_off: assert property (@(posedge pclk) disable iff (!presetn)
        !rfsh_en |=> !self_refresh) else $error("self refresh while refresh disabled");
    a_ack_row_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (!dds_reg && dma_master && dma_single && astate_reg == DRC_ACC_ROW) |=> !dma_ack_n)
        else $error("ack not low in row state");
    a_burst_dma_off: assert property (@(posedge pclk) disable iff (!presetn)
        (!dds_reg && dma_master && dma_single) |=> !burst_access)
        else $error("burst used for single address transfer");
    a_ack_cpu_high: assert property (@(posedge pclk) disable iff (!presetn)
        !dma_master |=> dma_ack_n) else $error("ack low for a non transfer master");
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        (stat_reg[DRC_EV_CMF] && ien_reg[DRC_EV_CMF] && !wr_iclr && !wr_ien) |=> irq)
        else $error("interrupt low with enabled status set");
endmodule
`default_nettype wire

//--- drc_pkg.sv
// Package with register map, field positions, reset values and state encodings.
// What this block does
// - Control register clears to zero on reset and on hardware standby entry.
// - Control register keeps its contents when software standby is entered.
// - Control register selects refresh mode, counter clock and timer; all bits R/W.
// - Refresh cycles start only while refresh enable (bit 7) is one.
// - With refresh disabled the refresh timer runs as an interval timer.
// - Wait insert zero: no wait state, RAS falls in the first refresh state.
// - Wait insert one: one wait state, RAS falls in first CAS refresh state.
// - Refresh enabled and bit 5 set: self-refresh driven during software standby.
// - Timing select chooses acknowledge timing and burst use for single-address DMA.
// - Timing select one: burst decided from address only, ignoring bus master.
// - Timing select one: acknowledge low from the first column state of access.
package drc_pkg;
    localparam logic [11:0] DRC_OFF_CTRL = 12'h000;
    localparam logic [11:0] DRC_OFF_DMA = 12'h004;
    localparam logic [11:0] DRC_OFF_CMP = 12'h008;
    localparam logic [11:0] DRC_OFF_CNT = 12'h00c;
    localparam logic [11:0] DRC_OFF_STAT = 12'h010;
    localparam logic [11:0] DRC_OFF_IEN = 12'h014;
    localparam logic [11:0] DRC_OFF_ICLR = 12'h018;
    localparam int DRC_BIT_RFSH_EN = 7;
    localparam int DRC_BIT_WAIT = 6;
    localparam int DRC_BIT_SELF = 5;
    localparam int DRC_BIT_CMF = 4;
    localparam int DRC_BIT_COMPARE_MATCH_IRQ_ENABLE = 3;
    localparam int DRC_BIT_DDS = 0;
    localparam int DRC_EV_CMF = 0;
    localparam int DRC_EV_RFSH = 1;
    localparam logic [7:0] DRC_CTRL_RESET = 8'h00;
    localparam logic [7:0] DRC_CMP_RESET = 8'hff;
    localparam logic [1:0] DRC_EV_RESET = 2'h0;
    typedef enum logic [2:0] {
        DRC_IDLE = 3'b000,
        DRC_RFSH_FIRST = 3'b001,
        DRC_RFSH_WAIT = 3'b010,
        DRC_RFSH_CAS1 = 3'b011,
        DRC_RFSH_CAS2 = 3'b100
    } drc_rstate_e;
    typedef enum logic [1:0] {
        DRC_ACC_IDLE = 2'b00,
        DRC_ACC_ROW = 2'b01,
        DRC_ACC_COL1 = 2'b10,
        DRC_ACC_COL2 = 2'b11
    } drc_astate_e;
endpackage

//--- drc_prescale.sv
// Prescaler that produces the refresh counter clock tick selected by three bits.
`timescale 1ns/100ps
`default_nettype none
module drc_prescale (
    input wire logic pclk, // System clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic [2:0] clk_sel, // Divide select, 2 to the power (2*sel+1).
    output logic tick // One-cycle tick at selected rate.
);
    logic [15:0] div_reg;
    logic [15:0] div_next;
    logic [15:0] bit_mask;
    assign div_next = div_reg + 16'h0001;
    assign bit_mask = 16'h0001 << (2 * clk_sel);
    // A tick fires when the selected bit of the free counter falls.
    assign tick = ((div_reg & bit_mask) != 16'h0000) && ((div_next & bit_mask) == 16'h0000);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 16'h0000;
        end else begin
            div_reg <= div_next;
        end
    end
endmodule
`default_nettype wire

//--- drc_sync.sv
// Three-stage synchroniser with agreement filter for an asynchronous level.
`timescale 1ns/100ps
`default_nettype none
module drc_sync (
    input wire logic pclk, // System clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic async_in, // Level from outside the clock domain.
    output logic level // Filtered level.
);
    logic [2:0] sh_reg;
    logic level_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        // Reset to the idle high level so that no false standby is seen after reset.
        if (!presetn) begin
            sh_reg <= 3'h7;
            level_reg <= 1'b1;
        end else begin
            sh_reg <= {sh_reg[1:0], async_in};
            if (sh_reg[1] == sh_reg[2]) begin
                level_reg <= sh_reg[2];
            end
        end
    end
    assign level = level_reg;
endmodule
`default_nettype wire

//--- drc_dram_model.sv
// Behavioural DRAM model that watches the strobes and records refresh cycles.
`timescale 1ns/100ps
`default_nettype none
module drc_dram_model (
    input wire logic pclk, // System clock.
    input wire logic ras_n, // Row strobe from the controller.
    input wire logic cas_n, // Column strobe from the controller.
    output int n_cbr, // Column-before-row refresh cycles seen.
    output int lag // Cycles from column to row strobe fall in the last refresh.
);
    int cas_cnt;
    logic ras_prev;
    initial begin
        n_cbr = 0;
        lag = -1;
        cas_cnt = 0;
        ras_prev = 1'b1;
    end
    // A row strobe falling while the column strobe is low, or falling with it, is a refresh.
    always @(posedge pclk) begin
        if (ras_prev && ras_n === 1'b0 && cas_n === 1'b0) begin
            n_cbr <= n_cbr + 1;
            lag <= cas_cnt;
        end
        cas_cnt <= (cas_n === 1'b0) ? cas_cnt + 1 : 0;
        ras_prev <= (ras_n !== 1'b0);
    end
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking testbench for the DRAM refresh control block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import drc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic hw_standby_n, sw_standby, dram_req, dram_addr_hit, dma_master, dma_single;
    logic burst_mode, ras_n, cas_n, refresh_busy, self_refresh, burst_access, dma_ack_n, irq;
    logic [7:0] v;
    logic ack_timing_select, ack_row, ack_col, bst;
    int n_fail, n_checks, cyc, n_cbr, lag, k0;

    drc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hw_standby_n(hw_standby_n), .sw_standby(sw_standby),
        .dram_req(dram_req), .dram_addr_hit(dram_addr_hit), .dma_master(dma_master),
        .dma_single(dma_single), .burst_mode(burst_mode), .ras_n(ras_n), .cas_n(cas_n),
        .refresh_busy(refresh_busy), .self_refresh(self_refresh),
        .burst_access(burst_access), .dma_ack_n(dma_ack_n), .irq(irq));
    drc_dram_model dram (.pclk(pclk), .ras_n(ras_n), .cas_n(cas_n), .n_cbr(n_cbr), .lag(lag));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // The run is under a thousand cycles; this ceiling only catches a hang.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer, entered just after a rising edge; an idle cycle follows it.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {sw_standby, dram_req, dram_addr_hit, dma_master, dma_single, burst_mode} = '0;
        hw_standby_n = 1'b1;
        presetn = 1'b0;
        k0 = $urandom(32'hd723);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(DRC_OFF_CTRL); chk("ctrl_rst", 32'h0, r);
        rd(DRC_OFF_CMP); chk("cmp_rst", {24'h0, DRC_CMP_RESET}, r);
        rd(12'h0fc); chk("unmapped_err", 32'h1, {31'h0, e});
        repeat (4) begin
            v = {5'($urandom), 3'h7};
            wr(DRC_OFF_CTRL, {24'h0, v});
            rd(DRC_OFF_CTRL); chk("ctrl_rw", {24'h0, v}, r);
        end
        for (int i = 0; i < 4; i++) begin
            v = {i[1], 1'b0, i[0], 5'h07};
            wr(DRC_OFF_CTRL, {24'h0, v});
            sw_standby <= 1'b1;
            repeat (12) @(posedge pclk);
            chk("self_refresh", {31'h0, i[1] & i[0]}, {31'h0, self_refresh});
            rd(DRC_OFF_CTRL); chk("ctrl_keep", {24'h0, v}, r);
            sw_standby <= 1'b0;
            repeat (12) @(posedge pclk);
            chk("self_exit", 32'h0, {31'h0, self_refresh});
        end
        hw_standby_n <= 1'b0;
        repeat (8) @(posedge pclk);
        hw_standby_n <= 1'b1;
        repeat (8) @(posedge pclk);
        rd(DRC_OFF_CTRL); chk("ctrl_hwstby", 32'h0, r);
        k0 = n_cbr;
        wr(DRC_OFF_CMP, 32'h3);
        wr(DRC_OFF_CNT, 32'h0);
        wr(DRC_OFF_CTRL, 32'h0);
        repeat (40) @(posedge pclk);
        rd(DRC_OFF_STAT); chk("match_flag", 32'h1, {31'h0, r[0]});
        chk("irq_masked", 32'h0, {31'h0, irq});
        chk("no_refresh", k0, n_cbr);
        wr(DRC_OFF_IEN, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq_on", 32'h1, {31'h0, irq});
        wr(DRC_OFF_CMP, 32'hff);
        wr(DRC_OFF_CTRL, 32'h07);
        wr(DRC_OFF_ICLR, 32'h3);
        repeat (2) @(posedge pclk);
        rd(DRC_OFF_STAT); chk("stat_clr", 32'h0, r);
        chk("irq_off", 32'h0, {31'h0, irq});
        wr(DRC_OFF_CTRL, 32'h1f);
        repeat (2) @(posedge pclk);
        chk("irq_ctrl", 32'h1, {31'h0, irq});
        wr(DRC_OFF_CTRL, 32'h07);
        for (int w = 0; w < 2; w++) begin
            wr(DRC_OFF_CMP, 32'h3);
            wr(DRC_OFF_CNT, 32'h0);
            k0 = n_cbr;
            wr(DRC_OFF_CTRL, {24'h0, 1'b1, w[0], 6'h0});
            for (int c = 0; c < 40 && refresh_busy !== 1'b1; c++) begin
                @(posedge pclk);
            end
            chk("busy_seen", 32'h1, {31'h0, refresh_busy});
            repeat (100) @(posedge pclk);
            wr(DRC_OFF_CTRL, 32'h07);
            repeat (10) @(posedge pclk);
            chk("busy_off", 32'h0, {31'h0, refresh_busy});
            chk("cbr_seen", 32'h1, {31'h0, n_cbr > k0});
            chk("ras_lag", 2 * w, lag);
            k0 = n_cbr;
            repeat (100) @(posedge pclk);
            chk("cbr_off", k0, n_cbr);
        end
        dram_addr_hit <= 1'b1;
        dma_single <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            ack_timing_select = (i < 4) ? i[0] : 1'($urandom);
            wr(DRC_OFF_DMA, {31'h0, ack_timing_select});
            dma_master <= (i < 4) ? i[1] : 1'($urandom);
            burst_mode <= 1'($urandom);
            dram_req <= 1'b1;
            @(posedge pclk);
            dram_req <= 1'b0;
            ack_row = 1'bx;
            for (int c = 0; c < 10 && cas_n !== 1'b0; c++) begin
                @(posedge pclk);
                if (ras_n === 1'b0 && cas_n === 1'b1) ack_row = dma_ack_n;
            end
            ack_col = dma_ack_n;
            bst = burst_access;
            chk("ack_row", {31'h0, !(dma_master && !ack_timing_select)}, {31'h0, ack_row});
            chk("ack_col", {31'h0, !dma_master}, {31'h0, ack_col});
            chk("burst", {31'h0, burst_mode && (ack_timing_select || !dma_master)}, {31'h0, bst});
            repeat (6) @(posedge pclk);
        end
        close_out();
    end
endmodule
`default_nettype wire
